// *** beacon_keyer_pkg.sv ***
// shared constants, register map and types for the beacon keyer
package beacon_keyer_pkg;

  typedef logic [31:0] word_t;
  typedef logic [7:0]  addr_t;

  // clock and timing figures
  localparam int unsigned CLK_HZ         = 200_000_000;
  localparam int unsigned TIMING_HZ      = 64;
  localparam int unsigned SLOW_FACTOR    = 3;
  localparam int unsigned TONE_LOW_HZ    = 400;
  localparam int unsigned TONE_HIGH_HZ   = 1020;
  localparam int unsigned TICK_CYCLES    = CLK_HZ / TIMING_HZ;
  localparam int unsigned TONE_LOW_HALF  = CLK_HZ / (2 * TONE_LOW_HZ);
  localparam int unsigned TONE_HIGH_HALF = CLK_HZ / (2 * TONE_HIGH_HZ);
  localparam int unsigned DIV_W          = 24;

  // binary counter and its taps
  localparam int unsigned CNT_W     = 12;
  localparam int unsigned STEP_W    = 5;
  localparam int unsigned STEPS     = 32;
  localparam int unsigned FRAMES    = 8;
  localparam int unsigned FRAME_W   = 3;
  localparam int unsigned DOT_TAP   = 3;
  localparam int unsigned STEP_LSB  = 4;
  localparam int unsigned HALF_TAP  = 8;
  localparam int unsigned FRAME_LSB = 9;

  // fixed code positions
  localparam logic [STEP_W-1:0] LEAD_SPACE_END = 5'h03;
  localparam logic [STEP_W-1:0] FIRST_MARK     = 5'h03;
  localparam logic [STEP_W-1:0] BLIP_STEP      = 5'h1f;

  // register offsets (byte addresses)
  localparam addr_t REG_CTRL   = 8'h00;
  localparam addr_t REG_DASH   = 8'h04;
  localparam addr_t REG_SPACE1 = 8'h08;
  localparam addr_t REG_SPACE2 = 8'h0c;
  localparam addr_t REG_FRAME  = 8'h10;
  localparam addr_t REG_STATUS = 8'h14;

  // field positions and reset values
  localparam int unsigned CTRL_TONE_HIGH = 0;
  localparam int unsigned CTRL_CONT_TONE = 1;
  localparam int unsigned FRAME_SPACE_LSB = 8;
  localparam int unsigned ST_KEY      = 12;
  localparam int unsigned ST_TONE     = 13;
  localparam int unsigned ST_STANDBY1 = 14;
  localparam int unsigned ST_STANDBY2 = 15;
  localparam int unsigned ST_SLOW     = 16;
  localparam word_t REG_RESET = 32'h0000_0000;

endpackage : beacon_keyer_pkg

// *** beacon_morse_keyer.sv ***
// beacon identification keyer: counter, code steps, frames, keying
//
// Behaviour
// - 64 per second timing clock drives sequencing
// - 12-stage counter divides by two to 4096
// - stages five-eight form 2 Hz step number
// - stage nine picks one of two multiplexers
// - 32 steps, eight seconds, then wraps
// - frame is 64 bit periods, eight seconds
// - dot one bit, dash three bits
// - unlinked steps key 4 Hz dots
// - dash link holds key on whole step
// - space link forces key off, overriding dots
// - first three steps always space
// - step three never programmed
// - stages ten-twelve select eight frames in order
// - frame linked mark tones, space silences
// - tone 1020 Hz linked, 400 Hz removed
// - continuous tone mode holds keyed tone on
// - last step space unless standby two blips
// - standby one slows clock on space2 steps
`timescale 1ns/10ps
`default_nettype none
module beacon_morse_keyer
  import beacon_keyer_pkg::*;
#(
  parameter int unsigned TICKS     = beacon_keyer_pkg::TICK_CYCLES,
  parameter int unsigned LOW_HALF  = beacon_keyer_pkg::TONE_LOW_HALF,
  parameter int unsigned HIGH_HALF = beacon_keyer_pkg::TONE_HIGH_HALF
)(
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire beacon_keyer_pkg::addr_t wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire beacon_keyer_pkg::word_t wb_dat_i,
  output var  beacon_keyer_pkg::word_t wb_dat_o,
  output var  logic                    wb_ack_o,
  input  wire logic                    standby1_n_i,
  input  wire logic                    standby2_n_i,
  input  wire logic                    keying_off_i,
  output var  logic                    key_o,
  output var  logic                    keyed_tone_o
);

  import beacon_keyer_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  localparam int unsigned PINS = 3;

  wire logic [PINS-1:0] pin_raw = {keying_off_i, ~standby2_n_i, ~standby1_n_i};
  logic [PINS-1:0]      pin_meta;
  logic [PINS-1:0]      pin_sync;

  // two flops per pin; only the second stage is read by logic
  generate
    for (genvar p = 0; p < PINS; p++)
    begin : g_sync
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          pin_meta[p] <= 1'b0;
          pin_sync[p] <= 1'b0;
        end
        else
        begin
          pin_meta[p] <= pin_raw[p];
          pin_sync[p] <= pin_meta[p];
        end
      end
    end
  endgenerate

  wire logic standby1  = pin_sync[0];
  wire logic standby2  = pin_sync[1];
  wire logic keying_off = pin_sync[2]; // high while the panel switch is off

  //////////////////////////////////////////////////////////////////////////////
  // strap registers (software-held code bus links)

  logic [31:0]       ctrl;
  logic [STEPS-1:0]  dash_links;
  logic [STEPS-1:0]  space1_links;
  logic [STEPS-1:0]  space2_links;
  logic [31:0]       frame_links;

  //////////////////////////////////////////////////////////////////////////////
  // timing clock and binary counter

  keyer_timing_if tm ();

  timing_divider #(
    .TICKS (TICKS)
  ) u_timing (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .tm    (tm)
  );

  logic [CNT_W-1:0] keyer_bit_counter;

  // the tick is added in rather than used as an enable, so the counter
  // flop loads on every edge; the count still moves once per tick
  wire logic [CNT_W-1:0] tick_step  = {{(CNT_W-1){1'b0}}, tm.tick};
  wire logic [CNT_W-1:0] next_count = keyer_bit_counter + tick_step;

  // counter wraps from all ones to zero on its own, so frames repeat
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      keyer_bit_counter <= '0;
    else
      keyer_bit_counter <= next_count;
  end

  //////////////////////////////////////////////////////////////////////////////
  // counter taps

  // stage n of the counter is bit n-1; each halves the rate of the last
  wire logic               dot_rate_tap        = keyer_bit_counter[DOT_TAP];
  wire logic [3:0]         mux_index           = keyer_bit_counter[STEP_LSB +: 4];
  wire logic               mux_half_select_tap = keyer_bit_counter[HALF_TAP];
  wire logic [FRAME_W-1:0] frame_selector      = keyer_bit_counter[FRAME_LSB +: FRAME_W];

  // one of 32 step outputs: low half is the first mux, high half the second
  wire logic [STEP_W-1:0] step = {mux_half_select_tap, mux_index};

  // one-hot views of the two code multiplexers, feeding the strap gates below
  wire logic [15:0] code_step_mux_first  =
    mux_half_select_tap ? 16'h0000 : (16'h0001 << mux_index);
  wire logic [15:0] code_step_mux_second =
    mux_half_select_tap ? (16'h0001 << mux_index) : 16'h0000;

  //////////////////////////////////////////////////////////////////////////////
  // code bus: per-step program decode

  // step three is a mark by construction, so its links are ignored
  wire logic step_unprogrammed = (step == FIRST_MARK);

  // the leading steps stay silent so the code starts after a gap
  wire logic lead_space = (step < LEAD_SPACE_END);

  // the last step is a space unless standby two asks for the blip
  wire logic blip_space = (step == BLIP_STEP) & ~standby2;

  // full one-hot step view: first mux in the low half, second in the high
  // half; exactly one bit stands at any time, so at most one strap per bus is live
  wire logic [STEPS-1:0] step_onehot = {code_step_mux_second, code_step_mux_first};

  logic [STEPS-1:0] dash_hit;
  logic [STEPS-1:0] space1_hit;
  logic [STEPS-1:0] space2_step;

  // one strap gate per step output, like a link from a mux pin to a bus;
  // or-ing the gates keeps each bus a wired-or of the linked steps
  generate
    for (genvar s = 0; s < STEPS; s++)
    begin : g_step
      assign dash_hit[s]    = dash_links[s] & step_onehot[s];
      assign space1_hit[s]  = space1_links[s] & step_onehot[s];
      assign space2_step[s] = space2_links[s] & step_onehot[s];
    end
  endgenerate

  // step three links are masked here, after the or, so one gate covers all
  wire logic dash_program_gate  = (|dash_hit) & ~step_unprogrammed;
  wire logic space_program_gate =
    ((|space1_hit) & ~step_unprogrammed) | lead_space | blip_space;
  // limitation: a gap step strapped to both space buses slows and silences
  wire logic space2_hit = (|space2_step) & ~step_unprogrammed;

  // the slow clock only lasts as long as the marked gap step
  assign tm.slow = standby1 & space2_hit;

  // space beats dash if both are strapped: a silent error is safer on air
  wire logic code_key =
    space_program_gate ? 1'b0 :
    dash_program_gate  ? 1'b1 :
    dot_rate_tap;

  // dash step is two bit periods; adjoining dot's mark makes three

  //////////////////////////////////////////////////////////////////////////////
  // frame content selection

  wire logic [FRAMES-1:0] frame_mark_links  = frame_links[0 +: FRAMES];
  wire logic [FRAMES-1:0] frame_space_links = frame_links[FRAME_SPACE_LSB +: FRAMES];
  wire logic              frame_mark        = frame_mark_links[frame_selector];
  wire logic              frame_space       = frame_space_links[frame_selector];

  // whole-frame tone or silence, otherwise the programmed code
  wire logic frame_key =
    frame_mark  ? 1'b1 :
    frame_space ? 1'b0 :
    code_key;

  //////////////////////////////////////////////////////////////////////////////
  // keying output gate

  wire logic continuous_tone_mode = ctrl[CTRL_CONT_TONE];
  wire logic tone_high            = ctrl[CTRL_TONE_HIGH];

  // panel switch off silences everything, including continuous tone
  wire logic next_key =
    keying_off           ? 1'b0 :
    continuous_tone_mode ? 1'b1 :
    frame_key;

  logic tone;

  tone_generator #(
    .LOW_HALF  (LOW_HALF),
    .HIGH_HALF (HIGH_HALF)
  ) u_tone (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .high_sel_i (tone_high),
    .tone_o     (tone)
  );

  wire logic keying_output_gate = key_o & tone;

  // registered so both outputs come straight from flops
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      key_o        <= 1'b0;
      keyed_tone_o <= 1'b0;
    end
    else
    begin
      key_o        <= next_key;
      keyed_tone_o <= keying_output_gate;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // wishbone slave: decode

  wire logic req       = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire logic wr        = req & wb_we_i;
  wire logic hit_ctrl  = (wb_adr_i == REG_CTRL);
  wire logic hit_dash  = (wb_adr_i == REG_DASH);
  wire logic hit_sp1   = (wb_adr_i == REG_SPACE1);
  wire logic hit_sp2   = (wb_adr_i == REG_SPACE2);
  wire logic hit_frame = (wb_adr_i == REG_FRAME);
  wire logic hit_stat  = (wb_adr_i == REG_STATUS);

  // byte lanes expanded to a bit mask
  wire word_t lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                           {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  wire word_t status_word = {
    15'h0000,
    tm.slow,
    standby2,
    standby1,
    tone,
    key_o,
    keyer_bit_counter
  };

  // unmapped addresses read zero and still acknowledge
  wire word_t read_word =
    hit_ctrl  ? ctrl         :
    hit_dash  ? dash_links   :
    hit_sp1   ? space1_links :
    hit_sp2   ? space2_links :
    hit_frame ? frame_links  :
    hit_stat  ? status_word  :
    REG_RESET;

  // in ctrl and frame, only the two control bits and sixteen frame bits are storage
  localparam word_t CTRL_MASK  = 32'h0000_0003;
  localparam word_t FRAME_MASK = 32'h0000_ffff;

  wire word_t next_ctrl  = ((ctrl & ~lane_mask) | (wb_dat_i & lane_mask)) & CTRL_MASK;
  wire word_t next_dash  = (dash_links & ~lane_mask) | (wb_dat_i & lane_mask);
  wire word_t next_sp1   = (space1_links & ~lane_mask) | (wb_dat_i & lane_mask);
  wire word_t next_sp2   = (space2_links & ~lane_mask) | (wb_dat_i & lane_mask);
  wire word_t next_frame =
    ((frame_links & ~lane_mask) | (wb_dat_i & lane_mask)) & FRAME_MASK;

  //////////////////////////////////////////////////////////////////////////////
  // wishbone slave: registers

  // writes land on the same edge that raises ack
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl         <= REG_RESET;
      dash_links   <= REG_RESET;
      space1_links <= REG_RESET;
      space2_links <= REG_RESET;
      frame_links  <= REG_RESET;
    end
    else if (wr)
    begin
      if (hit_ctrl)
        ctrl <= next_ctrl;
      if (hit_dash)
        dash_links <= next_dash;
      if (hit_sp1)
        space1_links <= next_sp1;
      if (hit_sp2)
        space2_links <= next_sp2;
      if (hit_frame)
        frame_links <= next_frame;
    end
  end

  // one-cycle answer; ack drops the cycle after it is given
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= REG_RESET;
    end
    else
    begin
      wb_ack_o <= req;
      wb_dat_o <= (req & ~wb_we_i) ? read_word : REG_RESET;
    end
  end

endmodule : beacon_morse_keyer
`default_nettype wire

// *** keyer_checker_assertions.sv ***
// concurrent checks on the beacon keyer top ports
`timescale 1ns/10ps
`default_nettype none
module keyer_checker #(
  parameter int unsigned LOW_HALF = 5
)(
  input wire logic                    clk_i,
  input wire logic                    rst_i,
  input wire logic                    wb_cyc_i,
  input wire logic                    wb_stb_i,
  input wire logic                    wb_we_i,
  input wire beacon_keyer_pkg::addr_t wb_adr_i,
  input wire logic [3:0]              wb_sel_i,
  input wire beacon_keyer_pkg::word_t wb_dat_i,
  input wire beacon_keyer_pkg::word_t wb_dat_o,
  input wire logic                    wb_ack_o,
  input wire logic                    standby1_n_i,
  input wire logic                    standby2_n_i,
  input wire logic                    keying_off_i,
  input wire logic                    key_o,
  input wire logic                    keyed_tone_o
);
  import beacon_keyer_pkg::*;
  logic [7:0] same_n;
  logic       prev_tone;
  // run of an unchanged keyed tone while keyed; a stuck oscillator makes it grow
  always_ff @(posedge clk_i)
  begin
    prev_tone <= keyed_tone_o;
    if (rst_i)
      same_n <= 8'h00;
    else
      same_n <= (key_o && keyed_tone_o == prev_tone) ? same_n + 8'h01 : 8'h00;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////////
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in one cycle");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  a_tone_gated: assert property (keyed_tone_o |-> $past(key_o))
    else $error("tone without key");
  a_switch_off: assert property (keying_off_i [*4] |-> !key_o)
    else $error("key on while switch off");
  a_tone_running: assert property (same_n <= LOW_HALF + 2)
    else $error("keyed tone stuck while keyed");
  a_reset_clear: assert property (disable iff (1'b0) rst_i |=> !key_o && !keyed_tone_o
    && !wb_ack_o)
    else $error("outputs active after reset");
endmodule : keyer_checker
bind beacon_morse_keyer keyer_checker #(.LOW_HALF(LOW_HALF)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .standby1_n_i(standby1_n_i),
  .standby2_n_i(standby2_n_i), .keying_off_i(keying_off_i), .key_o(key_o),
  .keyed_tone_o(keyed_tone_o));
`default_nettype wire

// *** keyer_timing_if.sv ***
// timing tick and rate control between the divider and the keyer
`timescale 1ns/10ps
`default_nettype none
interface keyer_timing_if;
  logic tick;
  logic slow;
  modport source (output tick, input slow);
  modport sink   (input tick, output slow);
endinterface : keyer_timing_if
`default_nettype wire

// *** test_beacon_morse_keyer.sv ***
// self-checking testbench for the beacon keyer
`timescale 1ns/10ps
`default_nettype none
module test_beacon_morse_keyer;
  import beacon_keyer_pkg::*;
  localparam int unsigned LOW_H   = 5;
  localparam int unsigned HIGH_H  = 3;
  localparam word_t       DASH_V  = 32'h0010_0248;
  localparam word_t       SPACE_V = 32'h0000_1208;
  logic       clk_i    = 1'b0;
  logic       rst_i    = 1'b1;
  logic       wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  addr_t      wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  word_t      wb_dat_i = 32'h0, wb_dat_o, rd;
  logic       wb_ack_o, key_o, keyed_tone_o, sb2 = 1'b0;
  logic       standby1_n_i = 1'b1, standby2_n_i = 1'b1, keying_off_i = 1'b0;
  logic [7:0] half_len;
  int         cyc_n = 0, n_mismatch = 0, tests_run = 0;
  beacon_morse_keyer #(.TICKS(8), .LOW_HALF(LOW_H), .HIGH_HALF(HIGH_H)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .standby1_n_i(standby1_n_i),
    .standby2_n_i(standby2_n_i), .keying_off_i(keying_off_i), .key_o(key_o),
    .keyed_tone_o(keyed_tone_o));
  tone_receiver u_rx (.clk_i(clk_i), .keyed_tone_i(keyed_tone_o), .half_len_o(half_len));
  always #2.5 clk_i = ~clk_i;
  // cycles since reset release; the ceiling cuts a hang short
  always @(posedge clk_i)
  begin
    cyc_n <= rst_i ? 0 : cyc_n + 1;
    if (cyc_n > 31000)
    begin
      n_mismatch = n_mismatch + 1;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input word_t seen, input word_t exp);
    tests_run = tests_run + 1;
    if (seen !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one classic cycle; held until ack, then released for at least a cycle
  task automatic bus(input addr_t a, input word_t d, input logic w, input logic [3:0] s);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do
      @(posedge clk_i);
    while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : bus
  task automatic wait_to(input int t);
    while (cyc_n < t)
      @(posedge clk_i);
  endtask : wait_to
  // key level in bit period k; frames 2 and 5 silent, 1 and 6 keyed throughout
  function automatic logic exp_key(input int k);
    int st;
    int fr;
    st = (k / 2) % 32;
    fr = (k / 64) % 8;
    if (fr == 2 || fr == 5)
      return 1'b0;
    if (fr == 1 || fr == 6)
      return 1'b1;
    if (st < 3 || (SPACE_V[st] && st != 3) || (st == 31 && !sb2))
      return 1'b0;
    if (DASH_V[st] && st != 3)
      return 1'b1;
    return k[0];
  endfunction : exp_key
  task automatic final_report();
    $display("mismatches %0d, checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////////////////////
  // registers first, then each bit period from 2 to 457, slow gap last
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(REG_STATUS, 32'h0, 1'b0, 4'hf);
    check(rd & 32'h0001_dfff, 32'h0);
    bus(REG_CTRL, 32'h0, 1'b0, 4'hf);
    check(rd, REG_RESET);
    bus(REG_DASH, 32'hffff_ffff, 1'b1, 4'h0);
    bus(REG_DASH, DASH_V, 1'b1, 4'hf);
    bus(REG_DASH, 32'h0, 1'b0, 4'hf);
    check(rd, DASH_V);
    bus(REG_SPACE1, SPACE_V, 1'b1, 4'hf);
    bus(REG_SPACE2, 32'h0000_0020, 1'b1, 4'hf);
    bus(REG_FRAME, 32'habcd_0402, 1'b1, 4'hf);
    bus(REG_FRAME, 32'h0, 1'b0, 4'hf);
    check(rd, 32'h0000_0402);
    bus(REG_CTRL, 32'hffff_fff1, 1'b1, 4'hf);
    bus(REG_CTRL, 32'h0, 1'b0, 4'hf);
    check(rd, 32'h0000_0001);
    bus(8'h20, 32'hffff_ffff, 1'b1, 4'hf);
    bus(8'h20, 32'h0, 1'b0, 4'hf);
    check(rd, 32'h0);
    bus(REG_STATUS, 32'hffff_ffff, 1'b1, 4'hf);
    bus(REG_STATUS, 32'h0, 1'b0, 4'hf);
    check(rd & 32'h0001_c000, 32'h0);
    for (int k = 2; k < 458; k++)
    begin
      wait_to(64 * k);
      // panel and pin changes land on frame boundaries
      case (k)
        256: {standby2_n_i, sb2} <= 2'b01;
        320: {standby2_n_i, sb2, keying_off_i} <= 3'b101;
        384: {keying_off_i} <= 1'b0;
        448: standby1_n_i <= 1'b0;
        default: ;
      endcase
      if (k == 384)
        bus(REG_CTRL, 32'h0000_0002, 1'b1, 4'hf);
      if (k == 448)
        bus(REG_CTRL, 32'h0000_0001, 1'b1, 4'hf);
      wait_to(64 * k + 32);
      check(key_o, exp_key(k));
      if (k == 100)
        check(half_len, HIGH_H);
      if (k == 400)
        check(half_len, LOW_H);
    end
    wait_to(64 * 458 + 32);
    bus(REG_STATUS, 32'h0, 1'b0, 4'hf);
    check(rd & 32'h0001_4000, 32'h0001_4000);
    final_report();
  end
endmodule : test_beacon_morse_keyer
`default_nettype wire

// *** timing_divider.sv ***
// 64 pulse per second timing clock with a one-third rate option
`timescale 1ns/10ps
`default_nettype none
module timing_divider
  import beacon_keyer_pkg::*;
#(
  parameter int unsigned TICKS = beacon_keyer_pkg::TICK_CYCLES
)(
  input  wire logic      clk_i,
  input  wire logic      rst_i,
  keyer_timing_if.source tm
);

  localparam logic [DIV_W-1:0] LAST_NORMAL = DIV_W'(TICKS - 1);
  localparam logic [DIV_W-1:0] LAST_SLOW   = DIV_W'(TICKS * SLOW_FACTOR - 1);

  logic [DIV_W-1:0] count;
  logic             tick;
  wire logic [DIV_W-1:0] last = tm.slow ? LAST_SLOW : LAST_NORMAL;
  // >= so a drop back to full rate mid-period cannot overrun
  wire logic             wrap = (count >= last);

  // free running, restarts on reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      count <= '0;
      tick  <= 1'b0;
    end
    else
    begin
      count <= wrap ? '0 : count + 1'b1;
      tick  <= wrap;
    end
  end

  assign tm.tick = tick;

endmodule : timing_divider
`default_nettype wire

// *** tone_generator.sv ***
// square wave beacon tone at one of two pitches
`timescale 1ns/10ps
`default_nettype none
module tone_generator
  import beacon_keyer_pkg::*;
#(
  parameter int unsigned LOW_HALF  = beacon_keyer_pkg::TONE_LOW_HALF,
  parameter int unsigned HIGH_HALF = beacon_keyer_pkg::TONE_HIGH_HALF
)(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic high_sel_i,
  output var  logic tone_o
);

  localparam logic [DIV_W-1:0] LAST_LOW  = DIV_W'(LOW_HALF - 1);
  localparam logic [DIV_W-1:0] LAST_HIGH = DIV_W'(HIGH_HALF - 1);

  logic [DIV_W-1:0] count;
  wire logic [DIV_W-1:0] last = high_sel_i ? LAST_HIGH : LAST_LOW;
  wire logic             flip = (count >= last);

  // oscillator keeps running; keying gates it downstream
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      count  <= '0;
      tone_o <= 1'b0;
    end
    else
    begin
      count  <= flip ? '0 : count + 1'b1;
      tone_o <= flip ? ~tone_o : tone_o;
    end
  end

endmodule : tone_generator
`default_nettype wire

// *** tone_receiver.sv ***
// modulator driver stand-in: measures the half period of the keyed tone
`timescale 1ns/10ps
`default_nettype none
module tone_receiver (
  input  wire logic       clk_i,
  input  wire logic       keyed_tone_i,
  output var  logic [7:0] half_len_o
);
  logic [7:0] run_n = 8'h00;
  logic       last  = 1'b0;
  // length of the last whole level, latched at each edge of the tone
  always_ff @(posedge clk_i)
  begin
    last <= keyed_tone_i;
    if (keyed_tone_i != last)
    begin
      half_len_o <= run_n;
      run_n      <= 8'h01;
    end
    else
      run_n <= run_n + 8'h01;
  end
endmodule : tone_receiver
`default_nettype wire
